// ---- logic/fds_separator.sv ----
`timescale 1ns/1ps
module fds_separator (
  input wire logic ref_clk_i,           // Reference clock, 10 MHz.
  input wire logic sys_rst_i,           // Synchronous reset, active high.
  input wire logic raw_disk_pulse_n_i,  // Raw drive pulses, active low.
  input wire logic divider_select_lo_i, // Divider select, low bit.
  input wire logic divider_select_hi_i, // Divider select, high bit.
  input wire logic bit_ready_i,         // Receiver takes a recovered bit.
  output logic separated_window_clock_o, // Separated window clock.
  output logic separated_data_n_o,       // Separated data, active low.
  output logic bit_valid_o,              // Recovered bit available.
  output logic bit_data_o,               // Recovered bit value.
  output logic bit_accept_o              // Buffer has room for a bit.
);
  import fds_pkg::*;

  // ==========================================================================
  // Divider select decode, shared by the divider and its checker.
  function automatic logic [2:0] div_limit(input logic [1:0] sel);
    unique case (sel)
      2'h0: div_limit = 3'h0;
      2'h1: div_limit = 3'h1;
      2'h2: div_limit = 3'h3;
      default: div_limit = 3'h7;
    endcase
  endfunction

  // ==========================================================================
  // Synchronisers: the pins come from outside this clock's domain.
  logic [2:0] raw_reg, raw_next;
  logic [1:0] sel1_reg, sel1_next, sel_reg, sel_next;
  logic fall;

  always_comb begin
    raw_next = {raw_reg[1:0], raw_disk_pulse_n_i};
    sel1_next = {divider_select_hi_i, divider_select_lo_i};
    sel_next = sel1_reg;
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      raw_reg <= 3'h7;
      sel1_reg <= 2'h0;
      sel_reg <= 2'h0;
    end else begin
      raw_reg <= raw_next;
      sel1_reg <= sel1_next;
      sel_reg <= sel_next;
    end
  end

  // Leading (falling) edge of the active-low pulse.
  assign fall = raw_reg[2] & ~raw_reg[1];

  // ==========================================================================
  // Divider producing one internal tick every 1, 2, 4 or 8 cycles.
  logic [2:0] div_reg, div_next;
  logic tick;

  always_comb begin
    tick = (div_reg >= div_limit(sel_reg));
    div_next = tick ? 3'h0 : div_reg + 3'h1;
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      div_reg <= FDS_DIV_RST;
    end else begin
      div_reg <= div_next;
    end
  end

  // ==========================================================================
  // Window phase, correctors and separated outputs.
  logic [4:0] phase_reg, phase_next, period_reg, period_next;
  logic seen_reg, seen_next, emitted_reg, emitted_next;
  fds_err_t err_reg, err_next, long_reg, long_next;
  logic signed [7:0] integ_reg, integ_next;
  logic [2:0] pcnt_reg, pcnt_next;
  logic win_reg, win_next, separated_data_n_n_reg, separated_data_n_n_next;
  logic wrap, cur_seen, push;
  logic [4:0] half;
  fds_err_t edge_err, cur_err, short_corr, half_err;
  logic signed [7:0] integ_sum;

  always_comb begin
    half = period_reg >> 1;
    wrap = tick && (phase_reg == period_reg - 5'h1);
    edge_err = fds_err_t'({1'b0, phase_reg}) - fds_err_t'({1'b0, half});
    cur_seen = seen_reg | fall;
    cur_err = fall ? edge_err : err_reg;
    phase_next = phase_reg;
    period_next = period_reg;
    seen_next = seen_reg;
    err_next = err_reg;
    long_next = long_reg;
    integ_next = integ_reg;
    emitted_next = emitted_reg;
    pcnt_next = pcnt_reg;
    push = 1'b0;
    // Short-term corrector: half the phase error, clamped.
    half_err = cur_err >>> 1;
    if (half_err < FDS_SHORT_MIN) begin
      short_corr = FDS_SHORT_MIN;
    end else if (half_err > FDS_SHORT_MAX) begin
      short_corr = FDS_SHORT_MAX;
    end else begin
      short_corr = half_err;
    end
    integ_sum = integ_reg + 8'(cur_err);
    // An edge stores its phase error for this window.
    if (fall) begin
      seen_next = 1'b1;
      err_next = edge_err;
    end
    if (tick) begin
      phase_next = phase_reg + 5'h1;
      if (pcnt_reg != 3'h0) begin
        pcnt_next = pcnt_reg - 3'h1;
      end
    end
    // One data pulse per window, inside the data half.
    if (tick && !wrap && cur_seen && !emitted_reg &&
        (phase_reg + 5'h1 >= half)) begin
      pcnt_next = FDS_SEPARATED_DATA_N_TICKS;
      emitted_next = 1'b1;
    end
    if (wrap) begin
      phase_next = 5'h0;
      seen_next = 1'b0;
      err_next = '0;
      emitted_next = 1'b0;
      pcnt_next = 3'h0;
      push = 1'b1;
      // Long-term corrector integrates the error and steps slowly.
      if (integ_sum >= FDS_INTEG_TH) begin
        integ_next = '0;
        if (long_reg < FDS_LONG_MAX) begin
          long_next = long_reg + 6'sd1;
        end
      end else if (integ_sum <= -FDS_INTEG_TH) begin
        integ_next = '0;
        if (long_reg > FDS_LONG_MIN) begin
          long_next = long_reg - 6'sd1;
        end
      end else begin
        integ_next = integ_sum;
      end
      // Nominal 16, corrected 12 to 22.
      // Bounded steps keep the period between 12 and 22.
      period_next = 5'(FDS_NOM_PERIOD + 5'(short_corr) + 5'(long_next));
    end
    // Window clock is high in the first half of the period.
    win_next = (phase_next < (period_next >> 1));
    // Separated data is low while the pulse counter runs.
    separated_data_n_n_next = (pcnt_next == 3'h0);
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      phase_reg <= 5'h0;
      period_reg <= FDS_PERIOD_RST;
      seen_reg <= 1'b0;
      err_reg <= '0;
      long_reg <= '0;
      integ_reg <= '0;
      emitted_reg <= 1'b0;
      pcnt_reg <= 3'h0;
      win_reg <= 1'b1;
      separated_data_n_n_reg <= 1'b1;
    end else begin
      phase_reg <= phase_next;
      period_reg <= period_next;
      seen_reg <= seen_next;
      err_reg <= err_next;
      long_reg <= long_next;
      integ_reg <= integ_next;
      emitted_reg <= emitted_next;
      pcnt_reg <= pcnt_next;
      win_reg <= win_next;
      separated_data_n_n_reg <= separated_data_n_n_next;
    end
  end

  assign separated_window_clock_o = win_reg;
  assign separated_data_n_o = separated_data_n_n_reg;

  // ==========================================================================
  // Two-entry buffer for recovered bits; a full buffer drops the new bit,
  // since the disk cannot be stalled, and bit_accept_o tells the receiver.
  logic [1:0] mem_reg, mem_next, cnt_reg, cnt_next;
  logic wp_reg, wp_next, rp_reg, rp_next, do_push, do_pop;

  always_comb begin
    do_push = push && (cnt_reg != 2'h2);
    do_pop = bit_ready_i && (cnt_reg != 2'h0);
    mem_next = mem_reg;
    if (do_push) begin
      mem_next[wp_reg] = cur_seen;
    end
    wp_next = wp_reg ^ do_push;
    rp_next = rp_reg ^ do_pop;
    cnt_next = 2'(cnt_reg + {1'b0, do_push} - {1'b0, do_pop});
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      mem_reg <= 2'h0;
      cnt_reg <= 2'h0;
      wp_reg <= 1'b0;
      rp_reg <= 1'b0;
    end else begin
      mem_reg <= mem_next;
      cnt_reg <= cnt_next;
      wp_reg <= wp_next;
      rp_reg <= rp_next;
    end
  end

  assign bit_valid_o = (cnt_reg != 2'h0);
  assign bit_data_o = mem_reg[rp_reg];
  assign bit_accept_o = (cnt_reg != 2'h2);

  // ==========================================================================
  // Checks.
  logic [2:0] gap_reg;
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || tick) begin
      gap_reg <= 3'h0;
    end else begin
      gap_reg <= gap_reg + 3'h1;
    end
  end

  sequence s_wrap_nom;
    wrap && (long_next == 6'sd0) && (short_corr == 6'sd0);
  endsequence

  property p_div;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      tick && $stable(sel_reg) && !$past(tick) |->
        gap_reg == div_limit(sel_reg);
  endproperty
  a_div: assert property (p_div) else $error("divider gap wrong");
  property p_sync;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      fall |-> $past(raw_disk_pulse_n_i, 2) == 1'b0;
  endproperty
  a_sync: assert property (p_sync) else $error("edge not from pin");
  property p_edge;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      fall && !wrap |=> seen_reg && err_reg == $past(edge_err);
  endproperty
  a_edge: assert property (p_edge) else $error("edge not recorded");
  property p_nom;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      s_wrap_nom |=> period_reg == 5'd16;
  endproperty
  a_nom: assert property (p_nom) else $error("nominal not 16");
  property p_range;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      wrap |-> phase_reg >= 5'd11 && phase_reg <= 5'd21;
  endproperty
  a_range: assert property (p_range) else $error("period out of range");
  property p_long;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      long_reg >= -6'sd2 && long_reg <= 6'sd3 &&
      integ_reg < 8'sd16 && integ_reg > -8'sd16;
  endproperty
  a_long: assert property (p_long) else $error("long corrector range");
  property p_short;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      wrap && cur_err >= 6'sd8 |=> period_reg >= $past(period_reg);
  endproperty
  a_short: assert property (p_short) else $error("late edge shortened");
  property p_win;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      wrap |=> separated_window_clock_o ##0 phase_reg == 5'd0;
  endproperty
  a_win: assert property (p_win) else $error("window not restarted");
  property p_inside;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      !separated_data_n_o |-> !separated_window_clock_o;
  endproperty
  a_inside: assert property (p_inside) else $error("data outside window");
  property p_separated_data_n;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      $fell(separated_data_n_o) |-> $past(seen_reg) || $past(fall);
  endproperty
  a_separated_data_n: assert property (p_separated_data_n) else $error("data with no pulse");
  property p_full;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      cnt_reg == 2'h2 && !bit_ready_i |=> cnt_reg == 2'h2 && !bit_accept_o;
  endproperty
  a_full: assert property (p_full) else $error("buffer lost fullness");

endmodule

// ---- logic/fds_pkg.sv ----
// Operation
// - Internal clock is the reference clock divided by 1, 2, 4 or 8.
// - Leading edges of disk pulses adjust the window phase.
// - Without correction a window period is 16 internal clocks.
// - Every corrected window period stays within 12 to 22 internal clocks.
// - Separate short-term and long-term phase correctors are provided.
// - One active-low raw pulse input carries interleaved clock and data.
// - A separated window clock output frames the sampling windows.
// - Recovered data leaves on its own active-low separated data output.
package fds_pkg;

  // ==========================================================================
  // Window timing, counted in internal clock ticks.
  localparam logic [4:0] FDS_NOM_PERIOD = 5'h10;
  localparam logic [4:0] FDS_MIN_PERIOD = 5'h0c;
  localparam logic [4:0] FDS_MAX_PERIOD = 5'h16;
  localparam logic [2:0] FDS_SEPARATED_DATA_N_TICKS = 3'h4;

  // ==========================================================================
  // Corrector limits; short plus long spans -4 to +6 around nominal.
  localparam logic signed [5:0] FDS_SHORT_MIN = -6'sd2;
  localparam logic signed [5:0] FDS_SHORT_MAX = 6'sd3;
  localparam logic signed [5:0] FDS_LONG_MIN = -6'sd2;
  localparam logic signed [5:0] FDS_LONG_MAX = 6'sd3;
  localparam logic signed [7:0] FDS_INTEG_TH = 8'sd16;

  // ==========================================================================
  // Reset values.
  localparam logic [4:0] FDS_PERIOD_RST = FDS_NOM_PERIOD;
  localparam logic [2:0] FDS_DIV_RST = 3'h0;

  typedef logic signed [5:0] fds_err_t;

endpackage

// ---- tb/fds_drive_model.sv ----
`timescale 1ns/1ps
// ============================================================================
// Drive read-head model: emits raw pulses at a spacing set by the bench.
module fds_drive_model (
  input wire logic run_i,             // Emit pulses while high.
  input wire logic [15:0] gap_ns_i,   // Pulse spacing in nanoseconds.
  output logic raw_disk_pulse_n_o     // Raw pulse line, active low.
);
  // Pulses are 200 ns low so the synchroniser never misses one.
  // The start offset is odd on purpose, so edges never land on a clock edge.
  // Single active-low line.
  initial begin
    raw_disk_pulse_n_o = 1'b1;
    forever begin
      if (run_i !== 1'b1) begin
        wait (run_i === 1'b1);
        #37;
      end
      raw_disk_pulse_n_o = 1'b0;
      #200;
      raw_disk_pulse_n_o = 1'b1; // Line idles high between pulses.
      #(gap_ns_i - 16'd200);
    end
  end
endmodule

// ---- tb/fds_separator_test.sv ----
`timescale 1ns/1ps
module fds_separator_test;
  typedef struct packed {logic [1:0] sel; int hi; int per;} fds_row_s;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [1:0] sel = 2'h0;
  logic ready = 1'b1;
  logic run = 1'b0;
  logic [15:0] gap = 16'h0640;
  logic raw_n;
  logic wclk;
  logic separated_data_n_n;
  logic valid;
  logic data;
  logic accept;
  int error_cnt = 0;
  int check_count = 0;
  int hi;
  int lo;
  int dlow;
  int minp;
  int maxp;
  logic bad;
  fds_row_s rows [0:3] = '{'{2'h0, 8, 16}, '{2'h1, 16, 32},
                          '{2'h2, 32, 64}, '{2'h3, 64, 128}};

  // ==========================================================================
  // Clock, drive model and design.
  always #50 ref_clk_i = ~ref_clk_i;

  fds_drive_model drive_u (
    .run_i(run),
    .gap_ns_i(gap),
    .raw_disk_pulse_n_o(raw_n)
  );

  fds_separator dut_u (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .raw_disk_pulse_n_i(raw_n),
    .divider_select_lo_i(sel[0]),
    .divider_select_hi_i(sel[1]),
    .bit_ready_i(ready),
    .separated_window_clock_o(wclk),
    .separated_data_n_o(separated_data_n_n),
    .bit_valid_o(valid),
    .bit_data_o(data),
    .bit_accept_o(accept)
  );

  // ==========================================================================
  // Compare and bus tasks.
  task automatic check_bit(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic check_num(input string what, input int exp, input int got);
    check_count++;
    if (got != exp) begin
      error_cnt++;
      $display("ERROR %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // Reset is checked while still asserted, which also covers mid-run resets.
  task automatic do_reset();
    sys_rst_i = 1'b1;
    repeat (6) @(negedge ref_clk_i);
    check_bit("window clock in reset", 1'b1, wclk);
    check_bit("data in reset", 1'b1, separated_data_n_n);
    check_bit("valid in reset", 1'b0, valid);
    check_bit("accept in reset", 1'b1, accept);
    sys_rst_i = 1'b0;
  endtask

  // Measures one window from rising edge to rising edge, in ref cycles.
  // A data pulse in the high half is flagged; it belongs in the low half.
  task automatic measure(output int h, output int l, output int d,
                         output logic b);
    int n;
    h = 0;
    l = 0;
    d = 0;
    b = 1'b0;
    n = 0;
    while (wclk !== 1'b0 && n < 400) begin
      @(negedge ref_clk_i);
      n++;
    end
    while (wclk !== 1'b1 && n < 400) begin
      @(negedge ref_clk_i);
      n++;
    end
    while (wclk === 1'b1 && n < 400) begin
      if (separated_data_n_n !== 1'b1) b = 1'b1;
      h++;
      @(negedge ref_clk_i);
      n++;
    end
    while (wclk === 1'b0 && n < 400) begin
      if (separated_data_n_n === 1'b0) d++;
      l++;
      @(negedge ref_clk_i);
      n++;
    end
    check_bit("window measured in time", 1'b1, n < 400);
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Watchdog: the whole run needs well under 50000 cycles.
  initial begin
    #5000000;
    error_cnt++;
    $display("ERROR watchdog expected finish seen hang");
    finish_test();
  end

  // ==========================================================================
  // Main sequence.
  initial begin
    @(negedge ref_clk_i);
    // Divider table, no pulses, so the window runs at nominal length.
    // Reference clock and select pairing from the rows.
    foreach (rows[i]) begin
      sel = rows[i].sel;
      do_reset();
      measure(hi, lo, dlow, bad);
      check_num("high half", rows[i].hi, hi);
      check_num("window period", rows[i].per, hi + lo);
    end
    // Locked pulses: one 4-tick data pulse in the low half of a window.
    sel = 2'h0;
    do_reset();
    run = 1'b1;
    repeat (8) measure(hi, lo, dlow, bad);
    repeat (3) begin
      measure(hi, lo, dlow, bad);
      check_num("data pulse ticks", 4, dlow);
      check_bit("data pulse in high half", 1'b0, bad);
    end
    // Fast then slow drive: phase tracking bends the window, within limits.
    for (int k = 0; k < 2; k++) begin
      gap = (k == 0) ? 16'h0514 : 16'h07d0;
      minp = 99;
      maxp = 0;
      repeat (14) begin
        measure(hi, lo, dlow, bad);
        minp = (hi + lo < minp) ? hi + lo : minp;
        maxp = (hi + lo > maxp) ? hi + lo : maxp;
      end
      check_bit("period floor", 1'b1, minp >= 12);
      check_bit("period ceiling", 1'b1, maxp <= 22);
      check_bit("period tracks", 1'b1, k == 0 ? minp < 16 : maxp > 16);
    end
    // Buffer: stall the receiver until full, later bits are dropped.
    gap = 16'h0640;
    repeat (8) measure(hi, lo, dlow, bad);
    ready = 1'b0;
    repeat (3) measure(hi, lo, dlow, bad);
    run = 1'b0;
    repeat (2) measure(hi, lo, dlow, bad);
    check_bit("accept when full", 1'b0, accept);
    check_bit("valid when full", 1'b1, valid);
    check_bit("head bit", 1'b1, data);
    ready = 1'b1;
    @(negedge ref_clk_i);
    check_bit("second bit valid", 1'b1, valid);
    check_bit("second bit kept", 1'b1, data);
    @(negedge ref_clk_i);
    check_bit("valid after drain", 1'b0, valid);
    check_bit("accept after drain", 1'b1, accept);
    // Mid-run reset with the drive active.
    run = 1'b1;
    repeat (3) measure(hi, lo, dlow, bad);
    do_reset();
    finish_test();
  end
endmodule
